/* tmr_pkg.sv */
// Constants shared by the compare-output timer: register map, fields, modes and prescaler taps
// Functional notes
// - Force strobe in non-PWM modes applies the compare action like a real match.
// - Force strobe never sets the match flag, clears or reloads the counter.
// - Count write blocks any compare match at the next timer tick, even stopped.
// - Compare output state keeps its value across waveform mode changes.
// - Action field is not buffered; a new value governs the next match.
// - Nonzero action field routes compare output state to the pin in all modes.
// - Pin drives only while the direction bit selects output.
// - Action value zero leaves compare output state unchanged on matches.
// - Waveform mode sets counting; action field only selects output behaviour.
// - Normal mode always counts up, never clears on match, wraps 0xff to 0x00.
// - Normal mode sets overflow flag when count wraps 0xff to 0x00; cleared by service.
// - Normal mode accepts a count write at any time; as in every mode, it blocks the match at the next timer tick.
// - Clear-on-match mode counts up to compare value then clears to zero.
// - Compare value below count makes counter run through 0xff and wrap first.
// - Clear-on-match mode raises the match flag each time count reaches top.
// - Toggle action in clear-on-match mode toggles output on every match.
// - Prescale factor selectable among 1, 8, 32, 64, 128, 256 and 1024.
// - Clear-on-match mode sets overflow flag when count passes 0xff to 0x00.
// - Match sets flag at the timer tick; cleared by service or writing one.
// - Count write wins over clear or count in the same cycle.
// - Clock select zero stops the timer; count stays readable and writable.
// - Compare value is written directly, without double buffering.
package tmr_pkg;
    localparam int          CNT_W        = 8;
    localparam int          ADDR_W       = 8;
    localparam int          PRE_W        = 10;

    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_COUNT    = 8'h04;
    localparam logic [7:0]  OFS_COMPARE  = 8'h08;
    localparam logic [7:0]  OFS_FLAGS    = 8'h0c;
    localparam logic [7:0]  OFS_PIN      = 8'h10;

    // Control register fields
    localparam int          CTRL_WGM_LSB = 0;
    localparam int          CTRL_COM_LSB = 2;
    localparam int          CTRL_CS_LSB  = 4;
    localparam int          CTRL_FOC_BIT = 7;

    // Flag register fields
    localparam int          FLG_OVF_BIT  = 0;
    localparam int          FLG_CMF_BIT  = 1;

    // Pin register fields
    localparam int          PIN_DDR_BIT  = 0;
    localparam int          PIN_PORT_BIT = 1;
    localparam int          PIN_OUT_BIT  = 2;

    localparam logic [7:0]  CNT_MAX      = 8'hff;
    localparam logic [7:0]  CNT_BOTTOM   = 8'h00;
    localparam logic [7:0]  RST_BYTE     = 8'h00;

    // Waveform modes
    localparam logic [1:0]  WGM_NORMAL   = 2'h0;
    localparam logic [1:0]  WGM_PC_PWM   = 2'h1;
    localparam logic [1:0]  WGM_CTC      = 2'h2;
    localparam logic [1:0]  WGM_FAST_PWM = 2'h3;

    // Compare output actions in non-PWM modes
    localparam logic [1:0]  COM_NONE     = 2'h0;
    localparam logic [1:0]  COM_TOGGLE   = 2'h1;
    localparam logic [1:0]  COM_CLEAR    = 2'h2;
    localparam logic [1:0]  COM_SET      = 2'h3;

    // Prescaler taps: low bits of the divider that must all be one for a tick
    localparam logic [9:0]  TAP_DIV8     = 10'h007;
    localparam logic [9:0]  TAP_DIV32    = 10'h01f;
    localparam logic [9:0]  TAP_DIV64    = 10'h03f;
    localparam logic [9:0]  TAP_DIV128   = 10'h07f;
    localparam logic [9:0]  TAP_DIV256   = 10'h0ff;
    localparam logic [9:0]  TAP_DIV1024  = 10'h3ff;
endpackage

/* tmr_compare.sv */
// 8-bit timer with compare output unit, normal and clear-on-match modes, APB registers
`timescale 1ns/1ps
module tmr_compare
(
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rstn,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [tmr_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Interrupt service acknowledges
    input  wire logic                        ovf_service,
    input  wire logic                        cmp_service,
    // Compare output pin
    output logic                             pin_out,
    output logic                             pin_oe
);

    typedef struct packed {
        logic [7:0]  count;
        logic [7:0]  compare;
        logic [1:0]  wgm;
        logic [1:0]  com;
        logic [2:0]  cs;
        logic        ddr;
        logic        port;
        logic        oc;
        logic        ovf;
        logic        cmf;
        logic        block;
        logic [9:0]  pre;
        logic        ack;
        logic [31:0] rdata;
        logic        pin_out;
        logic        pin_oe;
    } tmr_state_s;

    tmr_state_s state_ff;
    tmr_state_s nxt_state;

    logic        access;
    logic        done;
    logic        mapped;
    logic        wr;
    logic        wr_ctrl;
    logic        wr_count;
    logic        tick;
    logic        hit;
    logic        non_pwm;
    logic        match;
    logic        force_now;
    logic [1:0]  act_com;
    logic [31:0] rd_mux;

    // Read mux
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            tmr_pkg::OFS_CTRL:
            begin
                rd_mux[tmr_pkg::CTRL_WGM_LSB +: 2] = state_ff.wgm;
                rd_mux[tmr_pkg::CTRL_COM_LSB +: 2] = state_ff.com;
                rd_mux[tmr_pkg::CTRL_CS_LSB +: 3]  = state_ff.cs;
            end
            tmr_pkg::OFS_COUNT:   rd_mux[7:0] = state_ff.count;
            tmr_pkg::OFS_COMPARE: rd_mux[7:0] = state_ff.compare;
            tmr_pkg::OFS_FLAGS:
            begin
                rd_mux[tmr_pkg::FLG_OVF_BIT] = state_ff.ovf;
                rd_mux[tmr_pkg::FLG_CMF_BIT] = state_ff.cmf;
            end
            tmr_pkg::OFS_PIN:
            begin
                rd_mux[tmr_pkg::PIN_DDR_BIT]  = state_ff.ddr;
                rd_mux[tmr_pkg::PIN_PORT_BIT] = state_ff.port;
                rd_mux[tmr_pkg::PIN_OUT_BIT]  = state_ff.oc;
            end
            default:              rd_mux = 32'h0000_0000;
        endcase
    end

    // Prescaler tick selection
    always_comb
    begin
        unique case (state_ff.cs)
            3'h0: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tick = (state_ff.pre & tmr_pkg::TAP_DIV8) == tmr_pkg::TAP_DIV8;
            3'h3: tick = (state_ff.pre & tmr_pkg::TAP_DIV32) == tmr_pkg::TAP_DIV32;
            3'h4: tick = (state_ff.pre & tmr_pkg::TAP_DIV64) == tmr_pkg::TAP_DIV64;
            3'h5: tick = (state_ff.pre & tmr_pkg::TAP_DIV128) == tmr_pkg::TAP_DIV128;
            3'h6: tick = (state_ff.pre & tmr_pkg::TAP_DIV256) == tmr_pkg::TAP_DIV256;
            3'h7: tick = state_ff.pre == tmr_pkg::TAP_DIV1024;
        endcase
    end

    always_comb
    begin
        access   = psel && penable;
        done     = access && state_ff.ack;
        mapped   = (paddr == tmr_pkg::OFS_CTRL) || (paddr == tmr_pkg::OFS_COUNT) ||
                   (paddr == tmr_pkg::OFS_COMPARE) || (paddr == tmr_pkg::OFS_FLAGS) ||
                   (paddr == tmr_pkg::OFS_PIN);
        wr       = done && pwrite && mapped;
        wr_ctrl  = wr && (paddr == tmr_pkg::OFS_CTRL);
        wr_count = wr && (paddr == tmr_pkg::OFS_COUNT);
        hit      = state_ff.count == state_ff.compare;
        non_pwm  = (state_ff.wgm == tmr_pkg::WGM_NORMAL) || (state_ff.wgm == tmr_pkg::WGM_CTC);
        // A blocked or overwritten tick produces no match
        match    = tick && hit && !state_ff.block && !wr_count;
        force_now = wr_ctrl && pwdata[tmr_pkg::CTRL_FOC_BIT] && non_pwm;
        // Action field is used live, with the freshly written value for a force
        act_com  = force_now ? pwdata[tmr_pkg::CTRL_COM_LSB +: 2] : state_ff.com;

        nxt_state     = state_ff;
        nxt_state.pre = state_ff.pre + 10'h001;

        // APB: one wait state, read data captured into a flop
        nxt_state.ack = access && !state_ff.ack;
        if (access && !state_ff.ack)
        begin
            nxt_state.rdata = rd_mux;
        end

        // Register writes
        if (wr_ctrl)
        begin
            nxt_state.wgm = pwdata[tmr_pkg::CTRL_WGM_LSB +: 2];
            nxt_state.com = pwdata[tmr_pkg::CTRL_COM_LSB +: 2];
            nxt_state.cs  = pwdata[tmr_pkg::CTRL_CS_LSB +: 3];
        end
        if (wr && (paddr == tmr_pkg::OFS_COMPARE))
        begin
            nxt_state.compare = pwdata[7:0];
        end
        if (wr && (paddr == tmr_pkg::OFS_PIN))
        begin
            nxt_state.ddr  = pwdata[tmr_pkg::PIN_DDR_BIT];
            nxt_state.port = pwdata[tmr_pkg::PIN_PORT_BIT];
        end

        // Match blocking window lasts until the next timer tick
        if (tick)
        begin
            nxt_state.block = 1'b0;
        end
        if (wr_count)
        begin
            nxt_state.block = 1'b1;
        end

        // Counter
        if (wr_count)
        begin
            nxt_state.count = pwdata[7:0];
        end
        else if (tick)
        begin
            if ((state_ff.wgm == tmr_pkg::WGM_CTC) && match)
            begin
                nxt_state.count = tmr_pkg::CNT_BOTTOM;
            end
            else
            begin
                nxt_state.count = state_ff.count + 8'h01;
            end
        end

        // Compare output state; a zero action leaves it alone
        if ((match && non_pwm) || force_now)
        begin
            unique case (act_com)
                tmr_pkg::COM_NONE:   nxt_state.oc = state_ff.oc;
                tmr_pkg::COM_TOGGLE: nxt_state.oc = !state_ff.oc;
                tmr_pkg::COM_CLEAR:  nxt_state.oc = 1'b0;
                tmr_pkg::COM_SET:    nxt_state.oc = 1'b1;
            endcase
        end

        // Flags: hardware set wins over a clear in the same cycle
        nxt_state.ovf = (state_ff.ovf && !ovf_service &&
                         !(wr && (paddr == tmr_pkg::OFS_FLAGS) && pwdata[tmr_pkg::FLG_OVF_BIT])) ||
                        (tick && !wr_count && (state_ff.count == tmr_pkg::CNT_MAX));
        nxt_state.cmf = (state_ff.cmf && !cmp_service &&
                         !(wr && (paddr == tmr_pkg::OFS_FLAGS) && pwdata[tmr_pkg::FLG_CMF_BIT])) ||
                        match;

        // Pin override, independent of the waveform mode
        nxt_state.pin_out = (nxt_state.com != tmr_pkg::COM_NONE) ? nxt_state.oc : nxt_state.port;
        nxt_state.pin_oe  = nxt_state.ddr;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign prdata  = state_ff.rdata;
    assign pready  = state_ff.ack;
    assign pslverr = state_ff.ack && !mapped;
    assign pin_out = state_ff.pin_out;
    assign pin_oe  = state_ff.pin_oe;

endmodule

/* tmr_compare_asserts.sv */
// Port-level assertions for the compare-output timer
`timescale 1ns/1ps
module tmr_compare_asserts
(
    // Clock and reset
    input wire logic                        clk_sys,
    input wire logic                        rstn,
    // APB
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [tmr_pkg::ADDR_W-1:0]  paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [31:0]                 prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    // Pin
    input wire logic                        pin_out,
    input wire logic                        pin_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    wire pin_wr = psel && penable && pready && pwrite && paddr == tmr_pkg::OFS_PIN;

    property p_rst; disable iff (1'b0) !rstn |=> !pready && !pslverr && !pin_oe && !pin_out && prdata == 32'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_acc; pready |-> psel && penable; endproperty
    a_acc: assert property (p_acc) else $error("ready outside access phase");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
    a_wait: assert property (p_wait) else $error("ready not after one wait state");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_unm; pready && !pwrite && paddr > tmr_pkg::OFS_PIN |-> pslverr && prdata == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not refused");
    property p_map; pready && paddr <= tmr_pkg::OFS_PIN && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
    a_map: assert property (p_map) else $error("mapped access refused");
    property p_hi; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits not zero");
    property p_oe; pin_wr |-> ##2 pin_oe == $past(pwdata[0], 2); endproperty
    a_oe: assert property (p_oe) else $error("pin enable does not follow direction");
    property p_oe_hold; $changed(pin_oe) |-> $past(pin_wr); endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("pin enable changed without write");
endmodule

bind tmr_compare tmr_compare_asserts u_chk (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_out(pin_out), .pin_oe(pin_oe));

/* tmr_compare_tb.sv */
// Self-checking bench for the compare-output timer
`timescale 1ns/1ps
module tmr_compare_tb;
    logic        clk_sys;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ovf_service;
    logic        cmp_service;
    logic        pin_out;
    logic        pin_oe;
    logic        err;
    int          miscompares = 0;
    int          n_compared  = 0;

    tmr_compare dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ovf_service(ovf_service), .cmp_service(cmp_service), .pin_out(pin_out), .pin_oe(pin_oe));

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    // Control word: mode, action, clock select, force strobe
    function automatic logic [31:0] cw(input logic [1:0] m, input logic [1:0] a, input logic [2:0] c, input logic f);
        return {24'h0, f, c, a, m};
    endfunction

    task automatic t_reset;
        for (int i = 0; i < 5; i++)
            rd(8'(4 * i), 32'h0);
        rd(8'h14, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask

    task automatic t_force;
        logic [1:0] act[5] = '{2'h3, 2'h1, 2'h0, 2'h1, 2'h2};
        logic       st[5]  = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        wr(tmr_pkg::OFS_CTRL, cw(2'h0, 2'h3, 3'h0, 1'b1));
        wr(tmr_pkg::OFS_PIN, 32'h3);
        for (int i = 0; i < 5; i++)
        begin
            wr(tmr_pkg::OFS_CTRL, cw(2'h0, act[i], 3'h0, 1'b1));
            rd(tmr_pkg::OFS_PIN, {29'h0, st[i], 2'h3});
            chk({31'h0, pin_out}, {31'h0, act[i] == 2'h0 ? 1'b1 : st[i]});
            chk({31'h0, pin_oe}, 32'h1);
        end
        rd(tmr_pkg::OFS_FLAGS, 32'h0);
        rd(tmr_pkg::OFS_COUNT, 32'h0);
    endtask

    task automatic t_normal;
        wr(tmr_pkg::OFS_COMPARE, 32'hfe);
        wr(tmr_pkg::OFS_COUNT, 32'hfe);
        wr(tmr_pkg::OFS_CTRL, cw(2'h0, 2'h1, 3'h1, 1'b0));
        wr(tmr_pkg::OFS_CTRL, cw(2'h0, 2'h1, 3'h0, 1'b0));
        rd(tmr_pkg::OFS_COUNT, 32'h2);
        rd(tmr_pkg::OFS_FLAGS, 32'h1);
        chk({31'h0, pin_out}, 32'h0);
        ovf_service <= 1'b1;
        @(posedge clk_sys);
        ovf_service <= 1'b0;
        rd(tmr_pkg::OFS_FLAGS, 32'h0);
    endtask

    task automatic t_ctc;
        int   div[7] = '{1, 8, 32, 64, 128, 256, 1024};
        int   n;
        logic s;
        wr(tmr_pkg::OFS_COMPARE, 32'h1);
        wr(tmr_pkg::OFS_COUNT, 32'h0);
        for (int i = 0; i < 7; i++)
        begin
            wr(tmr_pkg::OFS_CTRL, cw(2'h2, 2'h1, 3'(i + 1), 1'b0));
            for (int k = 0; k < 2; k++)
            begin
                s = pin_out;
                n = 0;
                while (pin_out === s && n < 5000)
                begin
                    @(posedge clk_sys);
                    n++;
                end
            end
            chk(32'(n), 32'(2 * div[i]));
        end
        wr(tmr_pkg::OFS_CTRL, cw(2'h2, 2'h3, 3'h0, 1'b1));
        rd(tmr_pkg::OFS_FLAGS, 32'h2);
        wr(tmr_pkg::OFS_CTRL, cw(2'h0, 2'h1, 3'h0, 1'b0));
        rd(tmr_pkg::OFS_PIN, 32'h7);
        wr(tmr_pkg::OFS_FLAGS, 32'h2);
        rd(tmr_pkg::OFS_FLAGS, 32'h0);
        // Count above compare must wrap first; zero action keeps the state
        wr(tmr_pkg::OFS_COUNT, 32'hfe);
        wr(tmr_pkg::OFS_CTRL, cw(2'h2, 2'h0, 3'h1, 1'b0));
        repeat (8) @(posedge clk_sys);
        wr(tmr_pkg::OFS_CTRL, cw(2'h2, 2'h0, 3'h0, 1'b0));
        rd(tmr_pkg::OFS_PIN, 32'h7);
        rd(tmr_pkg::OFS_FLAGS, 32'h3);
        cmp_service <= 1'b1;
        @(posedge clk_sys);
        cmp_service <= 1'b0;
        rd(tmr_pkg::OFS_FLAGS, 32'h1);
    endtask

    task automatic results;
        if (miscompares == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        rstn        = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h0;
        ovf_service = 1'b0;
        cmp_service = 1'b0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_force();
        t_normal();
        t_ctc();
        results();
    end

    // Longest scenario is the slowest prescaler, at most some 4096 cycles
    initial
    begin
        #100000;
        miscompares++;
        results();
    end
endmodule
